// *** rtl/gip_pkg.sv ***
// Behaviour
// - Slave only, any SCL rate to 400kHz
// - Answers one 7-bit bus address
// - SDA input when receiving, open-drain low otherwise
// - Master starts transactions, makes SCL, START, STOP
// - One bit per SCL cycle, SDA stable high
// - SDA change while SCL high is START/STOP
// - Idle bus rests high; STOP returns idle
// - START falls, STOP rises SDA under high SCL
// - Repeated START replaces STOP plus START
// - Acknowledge: SDA low across ninth clock pulse
// - No-acknowledge: SDA released across ninth pulse
// - Master watches acknowledges and retries failures; the host here flags nack and sends STOP, with no retry
// - Eight bits MSB first, then acknowledge
// - Register words go low byte first
// - Idle watches START plus address, then acknowledges
// - Bus address fixed at 0110110
// - Direction bit: 0 write, 1 read
// - Pointer byte, then data; pointer auto-increments
// - Drop writes past FFh or read-only
// - Reads past FFh return FFh
// - Master ends read with NACK then STOP/Sr
package gip_pkg;
  localparam logic [6:0] DEVICE_BUS_ADDRESS = 7'h36;
  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ = 1'b1;
  localparam logic [3:0] BIT_ACK = 4'h8;

  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned SCL_MAX_HZ = 400_000;
  // Quarter SCL period, rounded up so the rate never exceeds the limit
  localparam int unsigned QTR_CYC = (CLK_HZ + 4 * SCL_MAX_HZ - 1) / (4 * SCL_MAX_HZ);
  localparam int TICK_W = 5;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(QTR_CYC - 1);

  localparam logic [7:0] PTR_TOP = 8'hff;
  localparam logic [7:0] BYTE_PAST_TOP = 8'hff;

  localparam int RW_N = 8;
  localparam logic [RW_N-1:0][7:0] RW_OFS = {8'h4d, 8'h46, 8'h45, 8'h42, 8'h3f, 8'h3a, 8'h39, 8'h38};
  localparam logic [RW_N-1:0][15:0] RW_RST = {16'h0000, 16'h0c80, 16'h007d, 16'h0c00,
                                              16'he000, 16'h9c5c, 16'h262b, 16'h004b};
  localparam int IX_CELL_RES = 0;
  localparam int IX_TEMP_COEFF = 1;
  localparam int IX_EMPTY_V = 2;
  localparam int IX_SHUTDOWN = 3;
  localparam int IX_RESIDUAL = 4;
  localparam int IX_CHARGE_ACC = 5;
  localparam int IX_PERCENT_ACC = 6;
  localparam int IX_COULOMB = 7;

  localparam logic [7:0] OFS_STATE_FLAGS = 8'h3d;
  localparam logic [7:0] OFS_ELAPSED = 8'h3e;
  localparam logic [7:0] OFS_OCV_EST = 8'hfb;
  localparam logic [7:0] OFS_VCHG_PCT = 8'hff;
  localparam logic [7:0] TBL_BASE = 8'h80;
  localparam logic [7:0] TBL_LAST = 8'haf;
  localparam int TBL_N = 48;
  localparam logic [15:0] TBL_RST = 16'h0000;

  localparam logic [3:0] STEP_STOP_WR = 4'h5;
  localparam logic [3:0] STEP_STOP_RD = 4'h7;

  typedef enum logic [2:0] {DS_IDLE, DS_RX, DS_ACK, DS_TX, DS_RACK} gip_dst_e;
  typedef enum logic [1:0] {PH_ADDR, PH_PTR, PH_DATA} gip_phase_e;
  typedef enum logic {HS_IDLE, HS_RUN} gip_hst_e;
  typedef enum logic [2:0] {K_START, K_TX, K_RXA, K_RXN, K_STOP, K_END} gip_kind_e;
endpackage : gip_pkg

// *** rtl/gip_bus_if.sv ***
`timescale 1ns/1ps
interface gip_bus_if;
  logic scl;
  logic sda;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic d_sda_o;
  logic d_sda_oe;
  // Pull-up: a line is low only while some party drives it low
  assign scl = ~(m_scl_oe & ~m_scl_o);
  assign sda = ~((m_sda_oe & ~m_sda_o) | (d_sda_oe & ~d_sda_o));
  modport dev (input scl, input sda, output d_sda_o, output d_sda_oe);
  modport host (input scl, input sda, output m_scl_o, output m_scl_oe, output m_sda_o, output m_sda_oe);
endinterface : gip_bus_if

// *** rtl/gip_gauge_dev.sv ***
`timescale 1ns/1ps
module gip_gauge_dev
  import gip_pkg::*;
(
  input wire logic link_clk,
  input wire logic nrst,
  gip_bus_if.dev bus,
  input wire logic [15:0] gauge_state_flags,
  input wire logic [15:0] elapsed_time_count,
  input wire logic [15:0] open_circuit_voltage_est,
  input wire logic [15:0] voltage_based_charge_pct,
  output logic [15:0] cell_resistance_base,
  output logic [15:0] resistance_temp_coeff,
  output logic [15:0] empty_voltage_threshold,
  output logic [15:0] shutdown_countdown,
  output logic [15:0] residual_charge_third,
  output logic [15:0] charge_accumulator,
  output logic [15:0] percent_accumulator,
  output logic [15:0] coulomb_count_raw
);

  typedef struct packed {
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_last;
    logic sda_last;
    logic scl_f;
    logic sda_f;
    gip_dst_e st;
    gip_phase_e ph;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic rw;
    logic hi;
    logic ovf;
    logic mack;
    logic sda_oe;
    logic [7:0] ptr;
    logic [7:0] low;
    logic [RW_N-1:0][15:0] rwr;
    logic [TBL_N-1:0][15:0] tbl;
  } gip_dev_s;

  gip_dev_s dev_reg;
  gip_dev_s dev_next;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic advance;
  logic [15:0] rd_word;
  logic [7:0] tx_byte;

  function automatic logic in_table(input logic [7:0] p);
    return (p >= TBL_BASE) && (p <= TBL_LAST);
  endfunction : in_table

  // Reserved and lower addresses read as zero
  function automatic logic [15:0] word_at(input gip_dev_s s, input logic [7:0] p);
    logic [15:0] w;
    w = 16'h0000;
    for (int i = 0; i < RW_N; i++) begin
      if (p == RW_OFS[i]) begin
        w = s.rwr[i];
      end
    end
    if (in_table(p)) begin
      w = s.tbl[6'(p - TBL_BASE)];
    end
    case (p)
      OFS_STATE_FLAGS: w = gauge_state_flags;
      OFS_ELAPSED: w = elapsed_time_count;
      OFS_OCV_EST: w = open_circuit_voltage_est;
      OFS_VCHG_PCT: w = voltage_based_charge_pct;
      default: w = w;
    endcase
    return w;
  endfunction : word_at

  always_comb begin
    dev_next = dev_reg;
    advance = 1'b0;
    dev_next.scl_sync = {dev_reg.scl_sync[0], bus.scl};
    dev_next.sda_sync = {dev_reg.sda_sync[0], bus.sda};
    dev_next.scl_last = dev_reg.scl_sync[1];
    dev_next.sda_last = dev_reg.sda_sync[1];
    if (dev_reg.scl_sync[1] == dev_reg.scl_last) begin
      dev_next.scl_f = dev_reg.scl_last;
    end
    if (dev_reg.sda_sync[1] == dev_reg.sda_last) begin
      dev_next.sda_f = dev_reg.sda_last;
    end
    scl_rise = dev_next.scl_f & ~dev_reg.scl_f;
    scl_fall = ~dev_next.scl_f & dev_reg.scl_f;
    bus_start = dev_reg.scl_f & dev_next.scl_f & dev_reg.sda_f & ~dev_next.sda_f;
    bus_stop = dev_reg.scl_f & dev_next.scl_f & ~dev_reg.sda_f & dev_next.sda_f;
    rd_word = word_at(dev_reg, dev_reg.ptr);
    tx_byte = dev_reg.ovf ? BYTE_PAST_TOP : (dev_reg.hi ? rd_word[15:8] : rd_word[7:0]);

    if (bus_start) begin
      dev_next.st = DS_RX;
      dev_next.ph = PH_ADDR;
      dev_next.bitcnt = 4'h0;
      dev_next.sda_oe = 1'b0;
    end else if (bus_stop) begin
      dev_next.st = DS_IDLE;
      dev_next.sda_oe = 1'b0;
    end else begin
      case (dev_reg.st)
        DS_IDLE: begin
          dev_next.sda_oe = 1'b0;
        end
        DS_RX: begin
          if (scl_rise && dev_reg.bitcnt != BIT_ACK) begin
            dev_next.shreg = {dev_reg.shreg[6:0], dev_reg.sda_f};
            dev_next.bitcnt = dev_reg.bitcnt + 4'h1;
          end else if (scl_fall && dev_reg.bitcnt == BIT_ACK) begin
            dev_next.bitcnt = 4'h0;
            case (dev_reg.ph)
              PH_ADDR: begin
                if (dev_reg.shreg[7:1] == DEVICE_BUS_ADDRESS) begin
                  dev_next.sda_oe = 1'b1;
                  dev_next.rw = dev_reg.shreg[0];
                  dev_next.st = DS_ACK;
                end else begin
                  dev_next.st = DS_IDLE;
                end
              end
              PH_PTR: begin
                dev_next.ptr = dev_reg.shreg;
                dev_next.hi = 1'b0;
                dev_next.ovf = 1'b0;
                dev_next.sda_oe = 1'b1;
                dev_next.st = DS_ACK;
              end
              default: begin
                if (!dev_reg.hi) begin
                  dev_next.low = dev_reg.shreg;
                end else if (!dev_reg.ovf) begin
                  for (int i = 0; i < RW_N; i++) begin
                    if (dev_reg.ptr == RW_OFS[i]) begin
                      dev_next.rwr[i] = {dev_reg.shreg, dev_reg.low};
                    end
                  end
                  if (in_table(dev_reg.ptr)) begin
                    dev_next.tbl[6'(dev_reg.ptr - TBL_BASE)] = {dev_reg.shreg, dev_reg.low};
                  end
                end
                advance = 1'b1;
                dev_next.sda_oe = 1'b1;
                dev_next.st = DS_ACK;
              end
            endcase
          end
        end
        DS_ACK: begin
          if (scl_fall) begin
            dev_next.sda_oe = 1'b0;
            dev_next.st = DS_RX;
            if (dev_reg.ph == PH_ADDR) begin
              if (dev_reg.rw == DIR_READ) begin
                dev_next.ph = PH_DATA;
                dev_next.st = DS_TX;
                dev_next.shreg = tx_byte;
                dev_next.sda_oe = ~tx_byte[7];
              end else begin
                dev_next.ph = PH_PTR;
              end
            end else begin
              dev_next.ph = PH_DATA;
            end
          end
        end
        DS_TX: begin
          if (scl_rise) begin
            dev_next.bitcnt = dev_reg.bitcnt + 4'h1;
          end else if (scl_fall) begin
            if (dev_reg.bitcnt == BIT_ACK) begin
              dev_next.sda_oe = 1'b0;
              dev_next.st = DS_RACK;
              advance = 1'b1;
            end else begin
              dev_next.shreg = {dev_reg.shreg[6:0], 1'b1};
              dev_next.sda_oe = ~dev_reg.shreg[6];
            end
          end
        end
        DS_RACK: begin
          if (scl_rise) begin
            dev_next.mack = ~dev_reg.sda_f;
          end else if (scl_fall) begin
            dev_next.bitcnt = 4'h0;
            if (dev_reg.mack) begin
              dev_next.st = DS_TX;
              dev_next.shreg = tx_byte;
              dev_next.sda_oe = ~tx_byte[7];
            end else begin
              dev_next.st = DS_IDLE;
            end
          end
        end
        default: begin
          dev_next.st = DS_IDLE;
          dev_next.sda_oe = 1'b0;
        end
      endcase
    end

    if (advance) begin
      if (dev_reg.hi) begin
        dev_next.hi = 1'b0;
        dev_next.ptr = dev_reg.ptr + 8'h01;
        if (dev_reg.ptr == PTR_TOP) begin
          dev_next.ovf = 1'b1;
        end
      end else begin
        dev_next.hi = 1'b1;
      end
    end
  end

  // runs from the link clock; no rate setting
  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      dev_reg <= '0;
      dev_reg.scl_sync <= 2'h3;
      dev_reg.sda_sync <= 2'h3;
      dev_reg.scl_last <= 1'b1;
      dev_reg.sda_last <= 1'b1;
      dev_reg.scl_f <= 1'b1;
      dev_reg.sda_f <= 1'b1;
      dev_reg.st <= DS_IDLE;
      dev_reg.ph <= PH_ADDR;
      for (int i = 0; i < RW_N; i++) begin
        dev_reg.rwr[i] <= RW_RST[i];
      end
      for (int j = 0; j < TBL_N; j++) begin
        dev_reg.tbl[j] <= TBL_RST;
      end
    end else begin
      dev_reg <= dev_next;
    end
  end

  // Open drain: the data level is always low, only the enable moves
  assign bus.d_sda_o = 1'b0;
  assign bus.d_sda_oe = dev_reg.sda_oe;
  assign cell_resistance_base = dev_reg.rwr[IX_CELL_RES];
  assign resistance_temp_coeff = dev_reg.rwr[IX_TEMP_COEFF];
  assign empty_voltage_threshold = dev_reg.rwr[IX_EMPTY_V];
  assign shutdown_countdown = dev_reg.rwr[IX_SHUTDOWN];
  assign residual_charge_third = dev_reg.rwr[IX_RESIDUAL];
  assign charge_accumulator = dev_reg.rwr[IX_CHARGE_ACC];
  assign percent_accumulator = dev_reg.rwr[IX_PERCENT_ACC];
  assign coulomb_count_raw = dev_reg.rwr[IX_COULOMB];

endmodule : gip_gauge_dev

// *** rtl/gip_bus_host.sv ***
`timescale 1ns/1ps
module gip_bus_host
  import gip_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  gip_bus_if.host bus,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_ptr,
  input wire logic [15:0] cmd_wdata,
  output logic busy,
  output logic done,
  output logic nack,
  output logic [15:0] rdata
);

  typedef struct packed {
    gip_hst_e st;
    logic [1:0] q;
    logic [TICK_W-1:0] tick;
    logic [3:0] step;
    logic [3:0] bitn;
    logic [7:0] shreg;
    logic scl_oe;
    logic sda_oe;
    logic [1:0] sda_sync;
    logic wr;
    logic [7:0] ptr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic nack;
    logic busy;
    logic done;
  } gip_host_s;

  gip_host_s hst_reg;
  gip_host_s hst_next;
  gip_kind_e kind;
  logic [7:0] out_byte;

  // write: S addr ptr lo hi P; read adds Sr addr lo hi P
  function automatic gip_kind_e step_kind(input logic wr, input logic [3:0] step);
    case (step)
      4'h0: return K_START;
      4'h1, 4'h2, 4'h4: return K_TX;
      4'h3: return wr ? K_TX : K_START;
      4'h5: return wr ? K_STOP : K_RXA;
      4'h6: return wr ? K_END : K_RXN;
      4'h7: return K_STOP;
      default: return K_END;
    endcase
  endfunction : step_kind

  always_comb begin
    hst_next = hst_reg;
    hst_next.done = 1'b0;
    hst_next.sda_sync = {hst_reg.sda_sync[0], bus.sda};
    kind = step_kind(hst_reg.wr, hst_reg.step);
    case (hst_reg.step)
      4'h1: out_byte = {DEVICE_BUS_ADDRESS, DIR_WRITE};
      4'h2: out_byte = hst_reg.ptr;
      4'h3: out_byte = hst_reg.wdata[7:0];
      4'h4: out_byte = hst_reg.wr ? hst_reg.wdata[15:8] : {DEVICE_BUS_ADDRESS, DIR_READ};
      default: out_byte = 8'h00;
    endcase
    case (hst_reg.st)
      HS_IDLE: begin
        hst_next.scl_oe = 1'b0;
        hst_next.sda_oe = 1'b0;
        if (cmd_valid) begin
          hst_next.st = HS_RUN;
          hst_next.busy = 1'b1;
          hst_next.wr = cmd_write;
          hst_next.ptr = cmd_ptr;
          hst_next.wdata = cmd_wdata;
          hst_next.nack = 1'b0;
          hst_next.step = 4'h0;
          hst_next.bitn = 4'h0;
          hst_next.q = 2'h0;
          hst_next.tick = '0;
        end
      end
      HS_RUN: begin
        hst_next.tick = hst_reg.tick + TICK_W'(1);
        if (hst_reg.tick == TICK_LAST) begin
          hst_next.tick = '0;
          hst_next.q = hst_reg.q + 2'h1;
          case (kind)
            K_START: begin
              case (hst_reg.q)
                2'h0: begin
                  hst_next.scl_oe = 1'b1;
                  hst_next.sda_oe = 1'b0;
                end
                2'h1: hst_next.scl_oe = 1'b0;
                2'h2: hst_next.sda_oe = 1'b1;
                default: begin
                  hst_next.scl_oe = 1'b1;
                  hst_next.step = hst_reg.step + 4'h1;
                end
              endcase
            end
            K_STOP: begin
              case (hst_reg.q)
                2'h0: begin
                  hst_next.scl_oe = 1'b1;
                  hst_next.sda_oe = 1'b1;
                end
                2'h1: hst_next.scl_oe = 1'b0;
                2'h2: hst_next.sda_oe = 1'b0;
                default: hst_next.step = hst_reg.step + 4'h1;
              endcase
            end
            K_END: begin
              hst_next.st = HS_IDLE;
              hst_next.busy = 1'b0;
              hst_next.done = 1'b1;
            end
            default: begin
              case (hst_reg.q)
                2'h0: begin
                  // SDA changes only while SCL low
                  hst_next.scl_oe = 1'b1;
                  if (kind == K_TX) begin
                    // MSB first, then release for acknowledge
                    if (hst_reg.bitn == 4'h0) begin
                      hst_next.shreg = out_byte;
                      hst_next.sda_oe = ~out_byte[7];
                    end else begin
                      hst_next.sda_oe = (hst_reg.bitn == BIT_ACK) ? 1'b0 : ~hst_reg.shreg[7];
                    end
                  end else begin
                    // ACK low byte, NACK the last
                    hst_next.sda_oe = (hst_reg.bitn == BIT_ACK) && (kind == K_RXA);
                  end
                end
                2'h1: hst_next.scl_oe = 1'b0;
                2'h2: begin
                  if (hst_reg.bitn == BIT_ACK) begin
                    // a device NACK is flagged on nack and the transfer skips to STOP, with no retry
                    if (kind == K_TX && hst_reg.sda_sync[1]) begin
                      hst_next.nack = 1'b1;
                    end
                  end else if (kind != K_TX) begin
                    hst_next.shreg = {hst_reg.shreg[6:0], hst_reg.sda_sync[1]};
                  end
                end
                default: begin
                  hst_next.scl_oe = 1'b1;
                  if (hst_reg.bitn == BIT_ACK) begin
                    hst_next.bitn = 4'h0;
                    hst_next.step = hst_reg.step + 4'h1;
                    if (hst_reg.nack) begin
                      hst_next.step = hst_reg.wr ? STEP_STOP_WR : STEP_STOP_RD;
                    end
                    if (kind == K_RXA) begin
                      hst_next.rdata[7:0] = hst_reg.shreg;
                    end else if (kind == K_RXN) begin
                      hst_next.rdata[15:8] = hst_reg.shreg;
                    end
                  end else begin
                    hst_next.bitn = hst_reg.bitn + 4'h1;
                    if (kind == K_TX) begin
                      hst_next.shreg = {hst_reg.shreg[6:0], 1'b1};
                    end
                  end
                end
              endcase
            end
          endcase
        end
      end
      default: hst_next.st = HS_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hst_reg <= '0;
      hst_reg.st <= HS_IDLE;
      hst_reg.sda_sync <= 2'h3;
    end else begin
      hst_reg <= hst_next;
    end
  end

  assign bus.m_scl_o = 1'b0;
  assign bus.m_sda_o = 1'b0;
  assign bus.m_scl_oe = hst_reg.scl_oe;
  assign bus.m_sda_oe = hst_reg.sda_oe;
  assign busy = hst_reg.busy;
  assign done = hst_reg.done;
  assign nack = hst_reg.nack;
  assign rdata = hst_reg.rdata;

endmodule : gip_bus_host

// *** verif/gip_bus_asserts.sv ***
`timescale 1ns/1ps
module gip_bus_asserts (
  input wire logic clk,
  input wire logic nrst,
  input wire logic link_clk,
  input wire logic link_nrst,
  input wire logic scl,
  input wire logic sda,
  input wire logic m_scl_o,
  input wire logic m_sda_o,
  input wire logic d_sda_o,
  input wire logic d_sda_oe
);
  logic scl_q;
  logic [4:0] bit_cnt;
  logic [5:0] hi_cnt;
  // Saturating, so a long read never looks like an address byte again
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scl_q <= 1'b1;
      bit_cnt <= 5'h00;
      hi_cnt <= 6'h00;
    end else begin
      scl_q <= scl;
      hi_cnt <= (!scl) ? 6'h00 : (hi_cnt == 6'h3f) ? hi_cnt : hi_cnt + 6'h01;
      if (scl && scl_q && $fell(sda)) begin
        bit_cnt <= 5'h00;
      end else if (scl && !scl_q && bit_cnt != 5'h1f) begin
        bit_cnt <= bit_cnt + 5'h01;
      end
    end
  end
  chk_dev_od: assert property (@(posedge link_clk) disable iff (!link_nrst)
    !d_sda_o) else $error("device sda not open drain");
  // Idle after a stop: both lines rest high and the host never drives a one
  chk_host_od: assert property (@(posedge clk) disable iff (!nrst)
    scl && $rose(sda) |=> (scl && sda && !m_scl_o && !m_sda_o) [*8]) else $error("bus not idle after stop");
  chk_dev_edge_late: assert property (@(posedge link_clk) disable iff (!link_nrst)
    $changed(d_sda_oe) |-> !scl && !$past(scl, 2)) else $error("device sda moved near high scl");
  chk_only_master: assert property (@(posedge clk) disable iff (!nrst)
    scl && $past(scl) && $changed(sda) |-> !d_sda_oe && !$past(d_sda_oe)) else $error("device moved sda");
  chk_stop_release: assert property (@(posedge link_clk) disable iff (!link_nrst)
    scl && $rose(sda) |=> !d_sda_oe [*8]) else $error("device drives after stop");
  chk_addr_ack: assert property (@(posedge clk) disable iff (!nrst)
    $rose(scl) && bit_cnt == 5'h08 |-> !sda [*8]) else $error("address not acknowledged");
  chk_ack_not_early: assert property (@(posedge clk) disable iff (!nrst)
    $rose(d_sda_oe) |-> bit_cnt >= 5'h08) else $error("device drove inside address byte");
  chk_scl_high_time: assert property (@(posedge clk) disable iff (!nrst)
    $fell(scl) |-> hi_cnt >= 6'h0f) else $error("scl high too short");
  cover property (@(posedge clk) disable iff (!nrst) $rose(scl) && bit_cnt == 5'h08);
  cover property (@(posedge clk) disable iff (!nrst) $rose(d_sda_oe) && bit_cnt > 5'h09);
  cover property (@(posedge link_clk) disable iff (!link_nrst) scl && $rose(sda));
endmodule : gip_bus_asserts

// *** verif/gauge_i2c_register_port_test.sv ***
`timescale 1ns/1ps
module gauge_i2c_register_port_test
  import gip_pkg::*;
;
  typedef struct {logic rd; logic [15:0] val;} gip_note_s;
  logic clk, link_clk, nrst, link_nrst;
  logic cmd_valid, cmd_write, busy, done, nack, a;
  logic [7:0] cmd_ptr, rb;
  logic [15:0] cmd_wdata, rdata, t0, t1;
  logic [15:0] rw_out [8];
  logic [15:0] ro_val [4];
  logic [15:0] wv [8];
  logic [7:0] ro_ofs [4] = '{OFS_STATE_FLAGS, OFS_ELAPSED, OFS_OCV_EST, OFS_VCHG_PCT};
  logic [7:0] bad [2] = '{8'h6e, 8'hec};
  logic [31:0] seed = 32'hcb80_d875;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cyc = 0;
  gip_note_s exp_q[$];
  gip_bus_if bus_a ();
  gip_bus_if bus_b ();
  gip_bus_host i_gip_bus_host (.clk(clk), .nrst(nrst), .bus(bus_a), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_ptr(cmd_ptr), .cmd_wdata(cmd_wdata), .busy(busy), .done(done), .nack(nack), .rdata(rdata));
  gip_gauge_dev i_gip_gauge_dev (.link_clk(link_clk), .nrst(link_nrst), .bus(bus_a),
    .gauge_state_flags(ro_val[0]), .elapsed_time_count(ro_val[1]), .open_circuit_voltage_est(ro_val[2]),
    .voltage_based_charge_pct(ro_val[3]), .cell_resistance_base(rw_out[0]), .resistance_temp_coeff(rw_out[1]),
    .empty_voltage_threshold(rw_out[2]), .shutdown_countdown(rw_out[3]), .residual_charge_third(rw_out[4]),
    .charge_accumulator(rw_out[5]), .percent_accumulator(rw_out[6]), .coulomb_count_raw(rw_out[7]));
  // Second end on its own bus, driven by hand for foreign addresses and reads past the top
  gip_gauge_dev i_gip_gauge_dev_b (.link_clk(link_clk), .nrst(link_nrst), .bus(bus_b),
    .gauge_state_flags(ro_val[0]), .elapsed_time_count(ro_val[1]), .open_circuit_voltage_est(ro_val[2]),
    .voltage_based_charge_pct(ro_val[3]), .cell_resistance_base(), .resistance_temp_coeff(),
    .empty_voltage_threshold(), .shutdown_countdown(), .residual_charge_third(),
    .charge_accumulator(), .percent_accumulator(), .coulomb_count_raw());
  gip_bus_asserts i_gip_bus_asserts (.clk(clk), .nrst(nrst), .link_clk(link_clk), .link_nrst(link_nrst),
    .scl(bus_a.scl), .sda(bus_a.sda), .m_scl_o(bus_a.m_scl_o), .m_sda_o(bus_a.m_sda_o),
    .d_sda_o(bus_a.d_sda_o), .d_sda_oe(bus_a.d_sda_oe));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Odd offset keeps the link clock unrelated in phase
  initial begin
    link_clk = 1'b0;
    #7;
    forever #40 link_clk = ~link_clk;
  end
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction : rnd
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic cmp16(input logic [15:0] got, input logic [15:0] ex, input string what);
    samples_checked++;
    if (got !== ex) begin
      n_mismatch++;
      $display("mismatch %0t %s got %h exp %h", $time, what, got, ex);
    end
  endtask : cmp16
  task automatic print_verdict();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict
  task automatic run(input logic wr, input logic [7:0] ptr, input logic [15:0] wd, input logic [15:0] ex);
    int n = 0;
    exp_q.push_back('{!wr, ex});
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_ptr = ptr;
    cmd_wdata = wd;
    tick(1);
    cmd_valid = 1'b0;
    cmp16({15'h0000, busy}, 16'h0001, "busy");
    while (done !== 1'b1 && n < 8000) begin
      tick(1);
      n++;
    end
    cmp16({15'h0000, done}, 16'h0001, "done");
    cmp16({15'h0000, busy}, 16'h0000, "busy after done");
    tick(1);
  endtask : run
  // Hand-driven bit: data while scl low, sampled at the end of scl high
  // High and low halves of 32 cycles keep the hand-made clock under 400kHz
  task automatic bb_bit(input logic b, output logic s);
    bus_b.m_sda_oe = ~b;
    tick(16);
    bus_b.m_scl_oe = 1'b0;
    tick(32);
    s = bus_b.sda;
    bus_b.m_scl_oe = 1'b1;
    tick(16);
  endtask : bb_bit
  // Sending all ones releases sda, so the same task reads a byte; last is the ninth bit
  task automatic bb_byte(input logic [7:0] v, input logic last, output logic [7:0] got, output logic ack);
    for (int i = 7; i >= 0; i--) bb_bit(v[i], got[i]);
    bb_bit(last, ack);
  endtask : bb_byte
  task automatic bb_cond(input logic s0, input logic s1);
    bus_b.m_sda_oe = s0;
    tick(16);
    bus_b.m_scl_oe = 1'b0;
    tick(16);
    bus_b.m_sda_oe = s1;
    tick(16);
    bus_b.m_scl_oe = s1;
    tick(16);
  endtask : bb_cond
  always @(posedge clk) begin
    gip_note_s nt;
    cyc++;
    if (done === 1'b1 && exp_q.size() > 0) begin
      nt = exp_q.pop_front();
      cmp16({15'h0000, nack}, 16'h0000, "nack");
      if (nt.rd) cmp16(rdata, nt.val, "rdata");
    end
    if (cyc == 90000) begin
      n_mismatch++;
      $display("mismatch %0t timeout", $time);
      print_verdict();
    end
  end
  initial begin
    nrst = 1'b0;
    link_nrst = 1'b0;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_ptr = 8'h00;
    cmd_wdata = 16'h0000;
    bus_b.m_scl_o = 1'b0;
    bus_b.m_sda_o = 1'b0;
    bus_b.m_scl_oe = 1'b0;
    bus_b.m_sda_oe = 1'b0;
    foreach (ro_val[i]) ro_val[i] = rnd();
    tick(12);
    nrst = 1'b1;
    @(posedge link_clk);
    #1;
    link_nrst = 1'b1;
    tick(8);
    foreach (rw_out[i]) cmp16(rw_out[i], RW_RST[i], "reset value");
    foreach (wv[i]) begin
      wv[i] = rnd();
      run(1'b1, RW_OFS[i], wv[i], 16'h0000);
      cmp16(rw_out[i], wv[i], "rw port");
    end
    for (int i = 0; i < 8; i += 3) run(1'b0, RW_OFS[i], 16'h0000, wv[i]);
    run(1'b1, OFS_STATE_FLAGS, rnd(), 16'h0000);
    foreach (rw_out[i]) cmp16(rw_out[i], wv[i], "ro write");
    foreach (ro_ofs[i]) run(1'b0, ro_ofs[i], 16'h0000, ro_val[i]);
    t0 = rnd();
    t1 = rnd();
    run(1'b1, TBL_BASE, t0, 16'h0000);
    run(1'b1, TBL_LAST, t1, 16'h0000);
    run(1'b0, TBL_BASE, 16'h0000, t0);
    run(1'b0, TBL_LAST, 16'h0000, t1);
    run(1'b0, 8'h3b, 16'h0000, 16'h0000);
    foreach (bad[i]) begin
      bb_cond(1'b0, 1'b1);
      bb_byte(bad[i], 1'b1, rb, a);
      cmp16({15'h0000, a}, 16'h0001, "foreign address");
      bb_cond(1'b0, 1'b1);
      bb_byte(8'h6c, 1'b1, rb, a);
      cmp16({15'h0000, a}, 16'h0000, "own address");
      bb_cond(1'b1, 1'b0);
    end
    // Read three bytes from the top address: the third lies past the top
    bb_cond(1'b0, 1'b1);
    bb_byte(8'h6c, 1'b1, rb, a);
    bb_byte(PTR_TOP, 1'b1, rb, a);
    bb_cond(1'b0, 1'b1);
    bb_byte(8'h6d, 1'b1, rb, a);
    cmp16({15'h0000, a}, 16'h0000, "read address");
    bb_byte(8'hff, 1'b0, rb, a);
    cmp16({8'h00, rb}, {8'h00, ro_val[3][7:0]}, "top low byte");
    bb_byte(8'hff, 1'b0, rb, a);
    cmp16({8'h00, rb}, {8'h00, ro_val[3][15:8]}, "top high byte");
    bb_byte(8'hff, 1'b1, rb, a);
    cmp16({8'h00, rb}, {8'h00, BYTE_PAST_TOP}, "past top");
    bb_cond(1'b1, 1'b0);
    print_verdict();
  end
endmodule : gauge_i2c_register_port_test
